// File: src/rxsw_pkg.sv
`default_nettype none
package rxsw_pkg;
    localparam int STAT_W        = 32;
    localparam int DATA_W        = 8;
    localparam int FIFO_DEPTH    = 32;
    localparam int LEN_W         = 14;
    localparam int BIT_FILT      = 30;
    localparam int BIT_LEN_LO    = 16;
    localparam int BIT_SUMM      = 15;
    localparam int BIT_BCAST     = 13;
    localparam int BIT_LENERR    = 12;
    localparam int BIT_RUNT      = 11;
    localparam int BIT_MCAST     = 10;
    localparam int BIT_LONG      = 7;
    localparam int BIT_LATECOL   = 6;
    localparam int BIT_ETYPE     = 5;
    localparam int BIT_WDOG      = 4;
    localparam int BIT_MEDIA     = 3;
    localparam int BIT_DRIBBLE   = 2;
    localparam int BIT_CRC       = 1;
    localparam logic [13:0] RUNT_BYTES   = 14'h0040;
    localparam logic [13:0] HDR_BYTES    = 14'h000e;
    localparam logic [13:0] MAX_BYTES    = 14'h05ee;
    localparam logic [15:0] MAX_PAYLOAD  = 16'h05dc;
    localparam logic [13:0] WDOG_BYTES   = 14'h0800;
    localparam logic [2:0]  DRIB_MII     = 3'h4;
    localparam logic [2:0]  DRIB_10M     = 3'h3;
    localparam logic [31:0] STAT_RESET   = 32'h0000_0000;

    // Per-frame facts reported by the receive MAC at frame end
    typedef struct packed {
        logic        filt_fail;
        logic        bcast;
        logic        mcast;
        logic [15:0] len_type;
        logic        late_col;
        logic        media_err;
        logic        crc_bad;
        logic [2:0]  drib_bits;
        logic        mode_10m;
    } rxsw_end_t;

    function automatic logic [LEN_W-1:0] rxsw_inc(
        input logic [LEN_W-1:0] v);
        rxsw_inc = (v == {LEN_W{1'b1}}) ? v : v + 14'h0001;
    endfunction
endpackage
`default_nettype wire

// File: src/rxsw_fifo.sv
`default_nettype none
module rxsw_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32
) (
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem[rd_q];

    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) wr_q <= wr_q + 1'b1;
            if (pop)  rd_q <= rd_q + 1'b1;
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    a_fifo_noover : assert property (@(posedge mclk) disable iff (!rst_n)
        cnt_q <= (AW+1)'(DEPTH)) else $error("fifo count beyond depth");
endmodule // rxsw_fifo
`default_nettype wire

// File: src/rxsw_ctrl.sv
`default_nettype none
module rxsw_ctrl
    import rxsw_pkg::*;
(
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic receive_enable_bit,
    input  wire logic in_frame,
    output logic      rx_active,
    output logic      stop_pulse
);
    typedef enum logic [2:0] {
        RXSW_IDLE = 3'b001,
        RXSW_RUN  = 3'b010,
        RXSW_DRAIN = 3'b100
    } rxsw_st_t;
    rxsw_st_t st_q;
    rxsw_st_t st_d;

    always_comb begin
        st_d = st_q;
        case (st_q)
            RXSW_IDLE:  if (receive_enable_bit) st_d = RXSW_RUN;
            RXSW_RUN:   if (!receive_enable_bit) st_d = RXSW_DRAIN;
            RXSW_DRAIN: if (!in_frame) st_d = RXSW_IDLE;
            default:    st_d = RXSW_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_q       <= RXSW_IDLE;
            stop_pulse <= 1'b0;
        end else begin
            st_q       <= st_d;
            stop_pulse <= (st_q == RXSW_DRAIN) && (st_d == RXSW_IDLE);
        end
    end
    assign rx_active = (st_q != RXSW_IDLE);

    a_stop_single : assert property (
        @(posedge mclk) disable iff (!rst_n)
        stop_pulse |=> !stop_pulse) else $error("stop pulse too long");
endmodule // rxsw_ctrl
`default_nettype wire

// File: src/rxsw_top.sv
`default_nettype none
module rxsw_top
    import rxsw_pkg::*;
(
    input  wire logic               mclk,
    input  wire logic               rst_n,
    input  wire logic               receive_enable_bit,
    input  wire logic               pass_bad_frames,
    input  wire logic               rx_start,
    input  wire logic               rx_byte_valid,
    input  wire logic [DATA_W-1:0]  rx_byte,
    input  wire logic               rx_media_err,
    input  wire logic               rx_collision,
    input  wire logic               rx_end,
    input  wire rxsw_end_t          rx_end_info,
    output logic                    rx_byte_ready,
    output logic                    data_valid,
    input  wire logic               data_ready,
    output logic [DATA_W-1:0]       data_word,
    input  wire logic               data_rd,
    input  wire logic               stat_rd,
    output logic                    stat_valid,
    output logic [STAT_W-1:0]       stat_word,
    output logic                    receiver_error_flag,
    output logic                    receiver_stopped_pulse,
    output logic                    rx_running_q
);
    ////////////////////////////////////////////////////////////////////
    // Receiver control
    logic rx_active;
    logic stop_p;
    logic in_frame_q;

    rxsw_ctrl i_rxsw_ctrl (
        .mclk               (mclk),
        .rst_n              (rst_n),
        .receive_enable_bit (receive_enable_bit),
        .in_frame           (in_frame_q),
        .rx_active          (rx_active),
        .stop_pulse         (stop_p)
    );

    ////////////////////////////////////////////////////////////////////
    // Frame counters and sticky per-frame errors
    logic [LEN_W-1:0] len_q;
    logic             media_q;
    logic             late_q;
    logic             wdog_q;
    logic             pending_q;
    logic             dfifo_in_ready;
    logic             dfifo_out_valid;
    logic [DATA_W-1:0] dfifo_out_data;

    wire frame_go  = rx_start && rx_active && !in_frame_q;
    wire byte_take = in_frame_q && rx_byte_valid && dfifo_in_ready;
    wire past_win  = (len_q >= RUNT_BYTES);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            in_frame_q <= 1'b0;
            len_q      <= '0;
            media_q    <= 1'b0;
            late_q     <= 1'b0;
            wdog_q     <= 1'b0;
        end else if (frame_go) begin
            in_frame_q <= 1'b1;
            len_q      <= '0;
            media_q    <= 1'b0;
            late_q     <= 1'b0;
            wdog_q     <= 1'b0;
        end else if (in_frame_q) begin
            if (byte_take) len_q <= rxsw_inc(len_q);
            if (rx_media_err) media_q <= 1'b1;
            if (rx_collision && past_win) late_q <= 1'b1;
            if (len_q > WDOG_BYTES) wdog_q <= 1'b1;
            if (rx_end) in_frame_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Status word composition
    // Include the byte taken on the closing cycle
    wire [13:0] len_now   = byte_take ? rxsw_inc(len_q) : len_q;
    wire        media_any = media_q || rx_media_err || rx_end_info.media_err;
    wire        late_any  = late_q || (rx_collision && past_win);
    wire        runt_b    = (len_now < RUNT_BYTES);
    wire        long_b    = (len_now > MAX_BYTES);
    wire        wdog_b    = wdog_q || (len_now > WDOG_BYTES);
    wire        crc_b     = rx_end_info.crc_bad || media_any;
    wire        etype_b   = (len_now >= HDR_BYTES) &&
                            (rx_end_info.len_type > MAX_PAYLOAD);
    wire [15:0] len_ext   = {2'b00, len_now};
    wire        lenerr_b  = !etype_b && (len_now >= HDR_BYTES) &&
                            (rx_end_info.len_type + 16'h000e + 16'h0004
                             != len_ext);
    wire [2:0]  drib_min  = rx_end_info.mode_10m ? DRIB_10M : DRIB_MII;
    wire        drib_b    = !late_any &&
                            ((rx_end_info.mode_10m &&
                              rx_end_info.drib_bits >= drib_min) ||
                             (!rx_end_info.mode_10m &&
                              rx_end_info.drib_bits == drib_min));
    wire        summ_b    = runt_b || long_b || late_any || crc_b;

    logic [STAT_W-1:0] stat_d;
    always_comb begin
        stat_d = STAT_RESET;
        stat_d[BIT_FILT]                    = rx_end_info.filt_fail;
        stat_d[BIT_LEN_LO +: LEN_W]         = len_now;
        stat_d[BIT_SUMM]                    = summ_b;
        stat_d[BIT_BCAST]                   = rx_end_info.bcast;
        stat_d[BIT_LENERR]                  = lenerr_b;
        stat_d[BIT_RUNT]                    = runt_b;
        stat_d[BIT_MCAST]                   = rx_end_info.mcast;
        stat_d[BIT_LONG]                    = long_b;
        stat_d[BIT_LATECOL]                 = late_any;
        stat_d[BIT_ETYPE]                   = etype_b;
        stat_d[BIT_WDOG]                    = wdog_b;
        stat_d[BIT_MEDIA]                   = media_any;
        stat_d[BIT_DRIBBLE]                 = drib_b;
        stat_d[BIT_CRC]                     = crc_b;
    end

    // Runt status words dropped unless pass-bad is set; runt bytes still enter the data FIFO
    wire frame_done = in_frame_q && rx_end;
    wire keep_frame = !runt_b || pass_bad_frames;

    ////////////////////////////////////////////////////////////////////
    // Data FIFO: bytes enter as they arrive, status follows at end
    rxsw_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) i_rxsw_fifo (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .in_valid  (byte_take),
        .in_ready  (dfifo_in_ready),
        .in_data   (rx_byte),
        .out_valid (dfifo_out_valid),
        .out_ready (data_ready),
        .out_data  (dfifo_out_data)
    );

    ////////////////////////////////////////////////////////////////////
    // Status FIFO, one word per kept frame, in order
    logic [STAT_W-1:0] smem [FIFO_DEPTH];
    logic [4:0]        s_wr_q;
    logic [4:0]        s_rd_q;
    logic [5:0]        s_cnt_q;
    logic [STAT_W-1:0] pend_word_q;

    wire s_full  = (s_cnt_q == 6'h20);
    wire s_empty = (s_cnt_q == 6'h00);
    // Push the word one cycle after the last byte is written
    wire s_push  = pending_q && !s_full;
    wire s_pop   = stat_rd && !s_empty;
    wire s_over  = pending_q && s_full;
    wire s_under = stat_rd && s_empty;
    wire d_under = data_rd && !dfifo_out_valid;
    wire [STAT_W-1:0] s_head = s_empty ? STAT_RESET : smem[s_rd_q];

    always_ff @(posedge mclk) begin
        if (s_push) begin
            smem[s_wr_q] <= pend_word_q;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pending_q   <= 1'b0;
            pend_word_q <= STAT_RESET;
            s_wr_q      <= '0;
            s_rd_q      <= '0;
            s_cnt_q     <= '0;
        end else begin
            pending_q <= frame_done && keep_frame;
            if (frame_done) pend_word_q <= stat_d;
            if (s_push) s_wr_q <= s_wr_q + 5'h01;
            if (s_pop)  s_rd_q <= s_rd_q + 5'h01;
            s_cnt_q <= s_cnt_q + {5'h00, s_push} - {5'h00, s_pop};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Registered outputs
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            receiver_error_flag    <= 1'b0;
            receiver_stopped_pulse <= 1'b0;
            rx_running_q           <= 1'b0;
            rx_byte_ready          <= 1'b0;
            data_valid             <= 1'b0;
            data_word              <= '0;
            stat_valid             <= 1'b0;
            stat_word              <= STAT_RESET;
        end else begin
            // Sticky; only reset clears it, reception continues
            if (s_over || s_under || d_under)
                receiver_error_flag <= 1'b1;
            receiver_stopped_pulse <= stop_p;
            rx_running_q           <= rx_active;
            rx_byte_ready          <= dfifo_in_ready;
            data_valid             <= dfifo_out_valid;
            data_word              <= dfifo_out_data;
            stat_valid             <= !s_empty;
            stat_word              <= s_head;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    sequence frame_end_s;
        frame_done && keep_frame && !s_full;
    endsequence

    sequence head_idle_s;
        stat_valid && !stat_rd && !$past(stat_rd);
    endsequence

    sequence stop_seen_s;
        receiver_stopped_pulse ##1 !receiver_stopped_pulse;
    endsequence

    sequence err_held_s;
        receiver_error_flag [*2];
    endsequence

    // Status push, frame drop and length handling, and status word contents
    a_push_after : assert property (
        @(posedge mclk) disable iff (!rst_n)
        frame_end_s |=> s_push) else $error("status not pushed");
    a_runt_drop : assert property (
        @(posedge mclk) disable iff (!rst_n)
        frame_done && runt_b && !pass_bad_frames |=> !pending_q)
        else $error("runt kept without pass-bad");
    a_resv_zero : assert property (
        @(posedge mclk) disable iff (!rst_n)
        stat_word[31] == 1'b0 && stat_word[14] == 1'b0 &&
        stat_word[9:8] == 2'b00 && stat_word[0] == 1'b0)
        else $error("reserved status bit set");
    a_summ_or : assert property (
        @(posedge mclk) disable iff (!rst_n)
        stat_valid |-> stat_word[BIT_SUMM] == (stat_word[BIT_RUNT] |
            stat_word[BIT_LONG] | stat_word[BIT_LATECOL] |
            stat_word[BIT_CRC])) else $error("summary bit wrong");
    a_drib_late : assert property (
        @(posedge mclk) disable iff (!rst_n)
        stat_valid |-> !(stat_word[BIT_DRIBBLE] && stat_word[BIT_LATECOL]))
        else $error("dribble with late collision");
    a_media_crc : assert property (
        @(posedge mclk) disable iff (!rst_n)
        stat_valid && stat_word[BIT_MEDIA] |-> stat_word[BIT_CRC])
        else $error("media error without crc bit");
    a_runt_len : assert property (
        @(posedge mclk) disable iff (!rst_n)
        stat_valid |-> stat_word[BIT_RUNT] ==
            (stat_word[BIT_LEN_LO +: LEN_W] < RUNT_BYTES))
        else $error("runt bit mismatch");
    a_long_bit : assert property (
        @(posedge mclk) disable iff (!rst_n)
        stat_valid |-> stat_word[BIT_LONG] ==
            (stat_word[BIT_LEN_LO +: LEN_W] > MAX_BYTES))
        else $error("long bit mismatch");
    a_long_keep : assert property (
        @(posedge mclk) disable iff (!rst_n)
        in_frame_q && rx_byte_valid && dfifo_in_ready && !rx_end
        && !frame_go |=> in_frame_q)
        else $error("long frame truncated");
    a_etype_runt : assert property (
        @(posedge mclk) disable iff (!rst_n)
        stat_valid && stat_word[BIT_LEN_LO +: LEN_W] < HDR_BYTES
        |-> !stat_word[BIT_ETYPE]) else $error("type bit on tiny runt");
    a_len_type : assert property (
        @(posedge mclk) disable iff (!rst_n)
        stat_valid |-> !(stat_word[BIT_LENERR] && stat_word[BIT_ETYPE]))
        else $error("length error on typed frame");
    a_late_runt : assert property (
        @(posedge mclk) disable iff (!rst_n)
        stat_valid && stat_word[BIT_LATECOL] |-> !stat_word[BIT_RUNT])
        else $error("late collision on runt");
    a_wdog_bit : assert property (
        @(posedge mclk) disable iff (!rst_n)
        stat_valid |-> stat_word[BIT_WDOG] ==
            (stat_word[BIT_LEN_LO +: LEN_W] > WDOG_BYTES))
        else $error("watchdog bit mismatch");
    a_head_hold : assert property (
        @(posedge mclk) disable iff (!rst_n)
        head_idle_s |=> $stable(stat_word))
        else $error("status head moved without pop");

    // Error flag
    a_err_sticky : assert property (
        @(posedge mclk) disable iff (!rst_n)
        s_under |=> err_held_s) else $error("error flag not raised");
    a_over_flag : assert property (
        @(posedge mclk) disable iff (!rst_n)
        s_over || d_under |=> receiver_error_flag)
        else $error("error flag missed overrun");
    a_err_hold : assert property (
        @(posedge mclk) disable iff (!rst_n)
        receiver_error_flag |=> receiver_error_flag)
        else $error("error flag dropped");

    // Receiver stop
    a_stop_out : assert property (
        @(posedge mclk) disable iff (!rst_n)
        stop_p |=> stop_seen_s) else $error("stopped pulse wrong");
endmodule // rxsw_top
`default_nettype wire

// File: testbench/rxsw_host_model.sv
`default_nettype none
module rxsw_host_model
    import rxsw_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic              pop_en,
    input  wire logic              drain_en,
    input  wire logic              bad_rd,
    input  wire logic              stat_valid,
    input  wire logic [STAT_W-1:0] stat_word,
    output logic                   stat_rd,
    output logic                   data_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [STAT_W-1:0] got_q[$];
    logic [1:0]        gap_q;

    assign data_ready = drain_en;

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stat_rd <= 1'b0;
            gap_q   <= 2'h0;
        end else begin
            stat_rd <= 1'b0;
            if (gap_q != 2'h0) begin
                gap_q <= gap_q - 2'h1;
            end else if (bad_rd || (pop_en && stat_valid)) begin
                // Let the registered head settle before the next pop
                stat_rd <= 1'b1;
                gap_q   <= 2'h3;
                if (stat_valid) got_q.push_back(stat_word);
            end
        end
    end
endmodule // rxsw_host_model
`default_nettype wire

// File: testbench/test_rxsw_top.sv
`default_nettype none
module test_rxsw_top
    import rxsw_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic              mclk, rst_n, receive_enable_bit, pass_bad_frames;
    logic              rx_start, rx_byte_valid, rx_media_err, rx_collision;
    logic              rx_end, rx_byte_ready, data_valid, data_ready;
    logic              data_rd, stat_rd, stat_valid, receiver_error_flag;
    logic              receiver_stopped_pulse, rx_running_q;
    logic              pop_en, drain_en, bad_rd;
    logic [DATA_W-1:0] rx_byte, data_word;
    logic [STAT_W-1:0] stat_word, got;
    rxsw_end_t         rx_end_info;
    int                bad_count, comparisons, cnt;

    rxsw_top i_rxsw_top (.mclk(mclk), .rst_n(rst_n),
        .receive_enable_bit(receive_enable_bit),
        .pass_bad_frames(pass_bad_frames), .rx_start(rx_start),
        .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte),
        .rx_media_err(rx_media_err), .rx_collision(rx_collision),
        .rx_end(rx_end), .rx_end_info(rx_end_info),
        .rx_byte_ready(rx_byte_ready), .data_valid(data_valid),
        .data_ready(data_ready), .data_word(data_word),
        .data_rd(data_rd), .stat_rd(stat_rd), .stat_valid(stat_valid),
        .stat_word(stat_word), .receiver_error_flag(receiver_error_flag),
        .receiver_stopped_pulse(receiver_stopped_pulse),
        .rx_running_q(rx_running_q));
    rxsw_host_model i_rxsw_host_model (.mclk(mclk), .rst_n(rst_n),
        .pop_en(pop_en), .drain_en(drain_en), .bad_rd(bad_rd),
        .stat_valid(stat_valid), .stat_word(stat_word),
        .stat_rd(stat_rd), .data_ready(data_ready));

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (2) @(posedge mclk);
        check({29'h0000_0000, stat_valid, receiver_error_flag, data_valid},
              32'h0000_0000);
    endtask

    // f: 0 filter fail, 1 bcast, 2 mcast, 3 crc, 4 media, 5 coll, 6 10M
    task automatic frame(input int n, input logic [15:0] lt,
                         input logic [7:0] f, input logic [2:0] d);
        rxsw_end_t e;
        e = '0;
        e.filt_fail = f[0];
        e.bcast = f[1];
        e.mcast = f[2];
        e.len_type = lt;
        e.crc_bad = f[3];
        e.media_err = f[4];
        e.late_col = f[5];
        e.mode_10m = f[6];
        e.drib_bits = d;
        @(posedge mclk);
        rx_start <= 1'b1;
        @(posedge mclk);
        rx_start <= 1'b0;
        for (int i = 1; i <= n; i++) begin
            rx_byte_valid <= 1'b1;
            rx_byte <= i[7:0];
            rx_media_err <= f[4] && i == 5;
            rx_collision <= f[5] && i == 70;
            rx_end <= i == n;
            rx_end_info <= (i == n) ? e : '0;
            @(posedge mclk);
        end
        rx_byte_valid <= 1'b0;
        rx_end <= 1'b0;
        rx_media_err <= 1'b0;
        rx_collision <= 1'b0;
    endtask

    function automatic logic [31:0] exp_of(input int n,
        input logic [15:0] lt, input logic [7:0] f, input logic [2:0] d);
        logic [31:0] s;
        logic [13:0] l;
        l = n[13:0];
        s = 32'h0000_0000;
        s[29:16] = l;
        s[30] = f[0];
        s[13] = f[1];
        s[10] = f[2];
        s[11] = l < RUNT_BYTES;
        s[12] = lt <= MAX_PAYLOAD && l >= HDR_BYTES
                && lt + 16'h0012 != {2'b00, l};
        s[7] = l > MAX_BYTES;
        s[6] = f[5];
        s[5] = lt > MAX_PAYLOAD && l >= HDR_BYTES;
        s[4] = l > WDOG_BYTES;
        s[3] = f[4];
        s[2] = !f[5] && (f[6] ? d >= DRIB_10M : d == DRIB_MII);
        s[1] = f[3] | f[4];
        s[15] = s[11] | s[7] | s[6] | s[1];
        return s;
    endfunction

    task automatic take(output logic [31:0] w);
        int k;
        for (k = 0; k < 60 && i_rxsw_host_model.got_q.size() == 0; k++)
            @(posedge mclk);
        if (k == 60) begin
            bad_count++;
            $display("Error at %0t: no status word", $time);
            end_of_test();
        end else begin
            w = i_rxsw_host_model.got_q.pop_front();
        end
    endtask

    // Bit 1 carries no meaning for runt, late collision or watchdog frames
    task automatic run(input int n, input logic [15:0] lt,
                       input logic [7:0] f, input logic [2:0] d);
        logic [31:0] s, m, w;
        s = exp_of(n, lt, f, d);
        m = (s[11] | s[6] | s[4]) ? 32'hffff_fffd : 32'hffff_ffff;
        frame(n, lt, f, d);
        take(w);
        check(w & m, s & m);
    endtask

    task automatic wait_flag();
        for (int k = 0; k < 12 && receiver_error_flag !== 1'b1; k++)
            @(posedge mclk);
        check({31'h0000_0000, receiver_error_flag}, 32'h0000_0001);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        bad_count = 0;
        comparisons = 0;
        {rst_n, receive_enable_bit, pass_bad_frames, rx_start} = 4'h0;
        {rx_byte_valid, rx_media_err, rx_collision, rx_end} = 4'h0;
        {data_rd, pop_en, drain_en, bad_rd} = 4'h0;
        rx_byte = 8'h00;
        rx_end_info = '0;
        do_reset();
        receive_enable_bit <= 1'b1;
        pass_bad_frames <= 1'b1;
        pop_en <= 1'b1;
        drain_en <= 1'b1;
        run(100, 16'h0800, 8'h02, 3'h0);
        run(80, 16'h003e, 8'h05, 3'h0);
        run(80, 16'h0032, 8'h00, 3'h0);
        run(70, 16'h0034, 8'h08, 3'h0);
        run(70, 16'h0034, 8'h00, 3'h4);
        run(70, 16'h0034, 8'h40, 3'h3);
        run(70, 16'h0034, 8'h00, 3'h3);
        run(70, 16'h0034, 8'h10, 3'h0);
        run(100, 16'h0800, 8'h20, 3'h4);
        run(64, 16'h0800, 8'h00, 3'h0);
        run(63, 16'h0800, 8'h00, 3'h0);
        run(13, 16'h0800, 8'h00, 3'h0);
        run(1518, 16'h0800, 8'h00, 3'h0);
        run(1519, 16'h0800, 8'h00, 3'h0);
        run(2100, 16'h0800, 8'h00, 3'h0);
        // Runt's status word dropped, next frame's word comes first
        pass_bad_frames <= 1'b0;
        frame(20, 16'h0800, 8'h00, 3'h0);
        run(66, 16'h0030, 8'h00, 3'h0);
        check(i_rxsw_host_model.got_q.size(), 32'h0000_0000);
        // Two words queued, popped in arrival order
        pop_en <= 1'b0;
        frame(70, 16'h0034, 8'h08, 3'h0);
        frame(80, 16'h003e, 8'h02, 3'h0);
        repeat (6) @(posedge mclk);
        pop_en <= 1'b1;
        take(got);
        check(got, exp_of(70, 16'h0034, 8'h08, 3'h0));
        take(got);
        check(got, exp_of(80, 16'h003e, 8'h02, 3'h0));
        // Data buffer filled while the host stalls, then drained
        pass_bad_frames <= 1'b1;
        drain_en <= 1'b0;
        repeat (4) @(posedge mclk);
        frame(32, 16'h0800, 8'h00, 3'h0);
        repeat (3) @(posedge mclk);
        check({31'h0000_0000, rx_byte_ready}, 32'h0000_0000);
        take(got);
        check({18'h0_0000, got[29:16]}, 32'h0000_0020);
        check({23'h00_0000, data_valid, data_word}, 32'h0000_0101);
        drain_en <= 1'b1;
        for (int k = 0; k < 80 && data_valid !== 1'b0; k++) @(posedge mclk);
        repeat (3) @(posedge mclk);
        check({30'h0000_0000, data_valid, rx_byte_ready}, 32'h0000_0001);
        // Stop while idle: one pulse, frames refused, then resume
        receive_enable_bit <= 1'b0;
        cnt = 0;
        repeat (8) begin
            @(posedge mclk);
            #1;
            if (receiver_stopped_pulse === 1'b1) cnt++;
        end
        check(cnt, 32'h0000_0001);
        check({31'h0000_0000, rx_running_q}, 32'h0000_0000);
        frame(70, 16'h0034, 8'h00, 3'h0);
        repeat (10) @(posedge mclk);
        check(i_rxsw_host_model.got_q.size(), 32'h0000_0000);
        receive_enable_bit <= 1'b1;
        run(70, 16'h0034, 8'h00, 3'h0);
        check({31'h0000_0000, rx_running_q}, 32'h0000_0001);
        // Status overrun, reception continues afterwards
        pop_en <= 1'b0;
        for (int k = 0; k < 32; k++) frame(1, 16'h0800, 8'h00, 3'h0);
        repeat (4) @(posedge mclk);
        check({31'h0000_0000, receiver_error_flag}, 32'h0000_0000);
        frame(1, 16'h0800, 8'h00, 3'h0);
        wait_flag();
        pop_en <= 1'b1;
        for (int k = 0; k < 32; k++) take(got);
        run(70, 16'h0034, 8'h08, 3'h0);
        check(i_rxsw_host_model.got_q.size(), 32'h0000_0000);
        do_reset();
        // Host pops an empty status queue
        bad_rd <= 1'b1;
        @(posedge mclk);
        bad_rd <= 1'b0;
        wait_flag();
        do_reset();
        // Host reads an empty data queue
        data_rd <= 1'b1;
        @(posedge mclk);
        data_rd <= 1'b0;
        wait_flag();
        do_reset();
        end_of_test();
    end
endmodule // test_rxsw_top
`default_nettype wire
